// file: kbl_pkg.sv
package kbl_pkg;

    // ------------------------------------------------------------
    // Character framing
    // ------------------------------------------------------------
    localparam int unsigned DATA_BITS      = 8;
    localparam int unsigned FRAME_BITS     = DATA_BITS + 2;
    localparam int unsigned PERIODS_PER_BIT = 16;
    localparam int unsigned SAMPLE_PERIOD  = PERIODS_PER_BIT / 2 - 1;

    // ------------------------------------------------------------
    // Pulse shaping: one link period is four link_clk quarters
    // ------------------------------------------------------------
    localparam int unsigned QUARTERS       = 4;
    localparam logic [1:0]  Q_LAST         = 2'h3;
    localparam logic [1:0]  Q_SHORT_HIGH   = 2'h2;

    // ------------------------------------------------------------
    // Line state code from the level sensing
    // ------------------------------------------------------------
    localparam logic [1:0]  LINE_LOW       = 2'h0;
    localparam logic [1:0]  LINE_MID       = 2'h1;
    localparam logic [1:0]  LINE_HIGH      = 2'h3;

    // ------------------------------------------------------------
    // Buffering and reset values
    // ------------------------------------------------------------
    localparam int unsigned TX_FIFO_DEPTH  = 16;
    localparam logic        DRIVE_RESET    = 1'b1;
    localparam logic [3:0]  CNT_RESET      = 4'h0;

    typedef struct packed {
        logic       frame_err;
        logic [7:0] data;
    } kbl_rx_s;

    typedef struct packed {
        logic       stop;
        logic [7:0] data;
        logic       start;
    } kbl_frame_s;

endpackage

// file: kbl_fifo.sv
`timescale 1ns/1ps

module kbl_fifo
    import kbl_pkg::*;
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int unsigned AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
            $error("kbl_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            count  <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule

// file: kbl_link.sv
`timescale 1ns/1ps

// Summary of operation
// R01 - Terminal end drives its clock and its data onto the one shared line.
// R02 - Keyboard end sends data only and never clocks the line.
// R03 - Each character: start bit, eight data bits, one stop bit.
// R04 - Both ends transmit at once; the line shows one of three states.
// R05 - Line at upper level: far end reported high.
// R06 - Line at lower level: far end reported low.
// R07 - Line at middle level: far end reported as inverse of own drive.
// R08 - Own transmitter changes must not glitch the recovered far level.
// R09 - Terminal supplies the keyboard clock on the link itself.
// R10 - Terminal data is carried by the width of each clock pulse.
// R11 - Idle or mark: pulses high three quarters of each period.
// R12 - Data one is three quarters high, data zero one quarter high.
// R13 - Each bit lasts sixteen link periods; a character spans 160.
// R14 - Falling edge of every pulse stays at the fixed period point.
// R15 - Keyboard averages duty per bit: quarter is zero, three quarters one; the keyboard model judges only the pulse at period 8 of each bit.
// R16 - Keyboard sends in the same framing, timed by the recovered clock.
// R17 - Recovered far level is a clean binary serial receive signal.
module kbl_link
    import kbl_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = TX_FIFO_DEPTH
) (
    // System clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Link clock, quarter-period rate
    input  wire logic       link_clk,
    // Transmit bytes from the terminal side
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    // Received bytes from the keyboard
    output logic [7:0]      rx_data,
    output logic            rx_frame_err,
    output logic            rx_valid,
    // Shared line, open collector
    input  wire logic [1:0] line_state,
    output logic            line_o,
    output logic            line_oe,
    // Recovered far-end level, link domain
    output logic            far_level
);

    generate
        if (FIFO_DEPTH < 2) begin : g_chk
            $error("kbl_link: FIFO_DEPTH must be at least 2");
        end
    endgenerate

    // ------------------------------------------------------------
    // Transmit buffer, system domain
    // ------------------------------------------------------------
    logic       fifo_valid;
    logic       fifo_ready;
    logic [7:0] fifo_data;

    kbl_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    // ------------------------------------------------------------
    // Word handoff to link domain, toggle handshake
    // ------------------------------------------------------------
    // Hold stays still while req and ack differ, so the link side
    // may sample it at any time after seeing the toggle.
    logic [7:0] tx_hold;
    logic       tx_req;
    logic       ack_s1;
    logic       ack_s2;
    logic       tx_ack;

    wire hand_busy = (tx_req != ack_s2);
    assign fifo_ready = !hand_busy;
    wire hand_load = fifo_valid && !hand_busy;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_hold <= 8'h00;
            tx_req  <= 1'b0;
        end else if (hand_load) begin
            tx_hold <= fifo_data;
            tx_req  <= !tx_req;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= tx_ack;
            ack_s2 <= ack_s1;
        end
    end

    // ------------------------------------------------------------
    // Link domain reset, asserted at once, released on link_clk
    // ------------------------------------------------------------
    logic lrst_s1;
    logic lrst_b;

    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            lrst_s1 <= 1'b0;
            lrst_b  <= 1'b0;
        end else begin
            lrst_s1 <= 1'b1;
            lrst_b  <= lrst_s1;
        end
    end

    // ------------------------------------------------------------
    // Quarter phase of the link period
    // ------------------------------------------------------------
    logic [1:0] phase;
    wire        period_end = (phase == Q_LAST);

    always_ff @(posedge link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Request crossing into link domain
    // ------------------------------------------------------------
    logic req_s1;
    logic req_s2;

    always_ff @(posedge link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
        end else begin
            req_s1 <= tx_req;
            req_s2 <= req_s1;
        end
    end

    wire word_waiting = (req_s2 != tx_ack);

    // ------------------------------------------------------------
    // Character transmitter, link domain
    // ------------------------------------------------------------
    typedef enum logic {TX_IDLE, TX_SEND} kbl_tx_e;

    kbl_tx_e    tx_st;
    kbl_tx_e    next_tx_st;
    logic [9:0] tx_shift;
    logic [3:0] tx_per;
    logic [3:0] tx_bit;

    kbl_frame_s new_frame;
    assign new_frame = '{stop: 1'b1, data: tx_hold, start: 1'b0}; // R03

    wire tx_start   = (tx_st == TX_IDLE) && word_waiting && period_end;
    wire bit_end    = period_end &&
                      (tx_per == 4'(PERIODS_PER_BIT - 1)); // R13
    wire frame_last = (tx_bit == 4'(FRAME_BITS - 1));

    always_comb begin
        next_tx_st = tx_st;
        unique case (tx_st)
            TX_IDLE: begin
                if (tx_start) begin
                    next_tx_st = TX_SEND;
                end
            end
            TX_SEND: begin
                if (bit_end && frame_last) begin
                    next_tx_st = TX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            tx_st <= TX_IDLE;
        end else begin
            tx_st <= next_tx_st;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            tx_shift <= '1;
            tx_per   <= CNT_RESET;
            tx_bit   <= CNT_RESET;
            tx_ack   <= 1'b0;
        end else if (tx_start) begin
            tx_shift <= new_frame;
            tx_per   <= CNT_RESET;
            tx_bit   <= CNT_RESET;
            tx_ack   <= req_s2;
        end else if (tx_st == TX_SEND && period_end) begin
            tx_per <= tx_per + 4'h1;
            if (bit_end) begin
                tx_shift <= {1'b1, tx_shift[9:1]};
                tx_bit   <= tx_bit + 4'h1;
            end
        end
    end

    // Idle line sends mark, so the clock never stops.
    wire tx_level = (tx_st == TX_SEND) ? tx_shift[0] : 1'b1; // R11

    // ------------------------------------------------------------
    // Pulse width modulation of the link clock
    // ------------------------------------------------------------
    // Quarters 0..2 high for a one, only quarter 2 for a zero; the
    // fall always lands at quarter 3, the keyboard's clock reference.
    logic line_drive;
    logic next_line_drive;

    always_comb begin
        next_line_drive = 1'b0;
        if (phase != Q_LAST) begin // R14
            next_line_drive = tx_level || (phase == Q_SHORT_HIGH); // R10 R12
        end
    end

    always_ff @(posedge link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            line_drive <= DRIVE_RESET;
            line_oe    <= 1'b0;
        end else begin
            line_drive <= next_line_drive; // R01 R09
            line_oe    <= !next_line_drive;
        end
    end

    // Open collector: only ever pulls low.
    assign line_o = 1'b0;

    // ------------------------------------------------------------
    // Line sensing and far-end recovery
    // ------------------------------------------------------------
    logic [1:0] line_s1;
    logic [1:0] line_s2;
    logic       own_d1;
    logic       own_d2;

    // Own drive delayed to match the sense path, so a change of our
    // own output is never seen as a far-end transition.
    always_ff @(posedge link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            line_s1 <= LINE_HIGH;
            line_s2 <= LINE_HIGH;
            own_d1  <= DRIVE_RESET;
            own_d2  <= DRIVE_RESET;
        end else begin
            line_s1 <= line_state;
            line_s2 <= line_s1;
            own_d1  <= line_drive; // R08
            own_d2  <= own_d1;
        end
    end

    wire is_high = (line_s2 == LINE_HIGH);
    wire is_low  = (line_s2 == LINE_LOW);
    wire is_mid  = (line_s2 == LINE_MID);
    wire far_now = is_high ? 1'b1 : // R05
                   is_low  ? 1'b0 : // R06
                   is_mid  ? !own_d2 : // R04 R07
                   far_level;

    always_ff @(posedge link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            far_level <= 1'b1;
        end else begin
            far_level <= far_now; // R17
        end
    end

    // ------------------------------------------------------------
    // Character receiver, sampled once per link period
    // ------------------------------------------------------------
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} kbl_rx_e;

    kbl_rx_e    rx_st;
    kbl_rx_e    next_rx_st;
    logic [3:0] rx_per;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    kbl_rx_s    rx_word;
    logic       rx_tgl;

    wire rx_mid_start = (rx_per == 4'(SAMPLE_PERIOD));
    wire rx_bit_done  = (rx_per == 4'(PERIODS_PER_BIT - 1)); // R13

    always_comb begin
        next_rx_st = rx_st;
        unique case (rx_st)
            RX_IDLE: begin
                if (period_end && !far_level) begin
                    next_rx_st = RX_START;
                end
            end
            RX_START: begin
                if (period_end && rx_mid_start) begin
                    next_rx_st = far_level ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (period_end && rx_bit_done && rx_bit == 3'h7) begin
                    next_rx_st = RX_STOP;
                end
            end
            RX_STOP: begin
                if (period_end && rx_bit_done) begin
                    next_rx_st = RX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            rx_st <= RX_IDLE;
        end else begin
            rx_st <= next_rx_st;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            rx_per   <= CNT_RESET;
            rx_bit   <= 3'h0;
            rx_shift <= 8'h00;
            rx_word  <= '0;
            rx_tgl   <= 1'b0;
        end else if (period_end) begin
            rx_per <= (rx_st == RX_IDLE || rx_st != next_rx_st)
                      ? CNT_RESET : rx_per + 4'h1;
            if (rx_st == RX_DATA && rx_bit_done) begin
                rx_shift <= {far_level, rx_shift[7:1]}; // R03
                rx_bit   <= rx_bit + 3'h1;
            end
            if (rx_st == RX_STOP && rx_bit_done) begin
                rx_word <= '{frame_err: !far_level, data: rx_shift};
                rx_tgl  <= !rx_tgl;
            end
        end
    end

    // ------------------------------------------------------------
    // Received word back to the system domain
    // ------------------------------------------------------------
    // rx_word is held for a whole character time after the toggle,
    // far longer than the crossing takes.
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_s1 <= 1'b0;
            rx_s2 <= 1'b0;
            rx_s3 <= 1'b0;
        end else begin
            rx_s1 <= rx_tgl;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
        end
    end

    wire rx_new = (rx_s2 != rx_s3);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_data      <= 8'h00;
            rx_frame_err <= 1'b0;
            rx_valid     <= 1'b0;
        end else begin
            rx_valid <= rx_new;
            if (rx_new) begin
                rx_data      <= rx_word.data;
                rx_frame_err <= rx_word.frame_err;
            end
        end
    end

endmodule

// file: kbl_link_asserts.sv
`timescale 1ns/1ps

module kbl_link_asserts
    import kbl_pkg::*;
(
    // Clocks and reset
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       link_clk,
    // Watched signals
    input wire logic       rx_valid,
    input wire logic [1:0] line_state,
    input wire logic       line_o,
    input wire logic       line_oe,
    input wire logic       far_level
);
    // ------
    // Line drive
    // ------
    oc_drive_a: assert property (
        @(posedge link_clk) disable iff (!rst_b) !line_o)
        else $error("line_o not held low");
    period_fixed_a: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        $rose(line_oe) |-> ##4 $rose(line_oe))
        else $error("pulse fall off the period grid");
    pulse_width_a: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        $rose(line_oe) |=> (line_oe [*2] or !line_oe [*2])
        ##1 !line_oe ##1 line_oe)
        else $error("pulse width not one or three quarters");
    clock_runs_a: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        $fell(line_oe) |-> ##[1:3] line_oe)
        else $error("link clock stopped");
    // ------
    // Far level; window allows two to four edges
    // ------
    far_high_a: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        (line_state == LINE_HIGH) [*3] |-> ##2 far_level)
        else $error("far level low on high line");
    far_low_a: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        (line_state == LINE_LOW) [*3] |-> ##2 !far_level)
        else $error("far level high on low line");
    mid_own_low_a: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        (line_state == LINE_MID && line_oe) [*3] |-> ##2 far_level)
        else $error("middle line, own low, far not high");
    mid_own_high_a: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        (line_state == LINE_MID && !line_oe) [*3] |-> ##2 !far_level)
        else $error("middle line, own high, far not low");
    rx_pulse_a: assert property (
        @(posedge clk) disable iff (!rst_b) rx_valid |=> !rx_valid)
        else $error("rx_valid longer than one cycle");
endmodule

bind kbl_link kbl_link_asserts u_asserts (
    .clk       (clk),
    .rst_b     (rst_b),
    .link_clk  (link_clk),
    .rx_valid  (rx_valid),
    .line_state(line_state),
    .line_o    (line_o),
    .line_oe   (line_oe),
    .far_level (far_level)
);

// file: kbl_kbd_model.sv
`timescale 1ns/1ps

module kbl_kbd_model (
    // Link clock and terminal level
    input  wire logic link_clk,
    input  wire logic term_level,
    // Data only, never a clock
    output logic      kb_level
);
    logic [7:0] got_data;
    logic       got_err;
    int         got_cnt = 0;
    logic [9:0] sh;
    logic       prev = 1'b1;
    logic       busy = 1'b0;
    logic       bit_v;
    int         hi = 0;
    int         ph;
    int         nb;
    event       tick;

    initial kb_level = 1'b1;

    // Falling line edge is the period reference
    always @(posedge link_clk) begin
        hi = hi + int'(term_level);
        if (prev && !term_level) begin
            bit_v = (hi >= 2);
            hi = 0;
            -> tick;
            if (busy) begin
                ph = ph + 1;
                if (ph % 16 == 8) begin
                    sh = {bit_v, sh[9:1]};
                    nb = nb + 1;
                end
                if (nb == 10) begin
                    got_data = sh[8:1];
                    got_err = !sh[9];
                    got_cnt = got_cnt + 1;
                    busy = 1'b0;
                end
            end else if (!bit_v) begin
                busy = 1'b1;
                ph = 0;
                nb = 0;
            end
        end
        prev = term_level;
    end

    // Bits change only on the recovered period edge
    task automatic send_byte(input logic [7:0] b, input logic stop);
        logic [9:0] fr;
        fr = {stop, b, 1'b0};
        for (int i = 0; i < 160; i++) begin
            @(tick);
            kb_level <= fr[i / 16];
        end
        @(tick);
        kb_level <= 1'b1;
    endtask
endmodule

// file: kbl_link_tb.sv
`timescale 1ns/1ps

module kbl_link_tb
    import kbl_pkg::*;
;
    logic       clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic       tx_valid = 1'b0;
    logic       tx_ready;
    logic [7:0] rx_data;
    logic       rx_frame_err;
    logic       rx_valid;
    logic [1:0] line_state;
    logic       line_o;
    logic       line_oe;
    logic       far_level;
    logic       kb_level;
    int         n_fail = 0;
    int         checked = 0;
    int         cyc = 0;
    int         far_lo = 0;

    always #25 clk = ~clk;
    always #24 link_clk = ~link_clk;

    // Zero-delay line; own end high is !line_oe
    assign line_state = (!line_oe && kb_level) ? LINE_HIGH :
                        (line_oe && !kb_level) ? LINE_LOW : LINE_MID;

    kbl_link DUT (
        .clk(clk), .rst_b(rst_b), .link_clk(link_clk),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_frame_err(rx_frame_err),
        .rx_valid(rx_valid), .line_state(line_state),
        .line_o(line_o), .line_oe(line_oe), .far_level(far_level)
    );
    kbl_kbd_model KBD (
        .link_clk(link_clk), .term_level(!line_oe), .kb_level(kb_level)
    );

    always @(posedge link_clk) if (far_level === 1'b0) far_lo++;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            $display("unexpected at %0t: run timed out", $time);
            conclude();
        end
    end

    // ------
    // Compare and wait helpers
    // ------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: byte %h not %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: flag %b not %b", $time, got, exp);
        end
    endtask

    task automatic wait_kbd(input int n);
        for (int t = 0; t < 2000 && KBD.got_cnt < n; t++) @(posedge clk);
        if (KBD.got_cnt < n) begin
            n_fail++;
            $display("unexpected at %0t: keyboard got no byte", $time);
        end
    endtask

    // rx_valid stands one cycle, so look at every edge
    task automatic wait_rx();
        int t;
        for (t = 0; t < 3000; t++) begin
            @(posedge clk);
            #1;
            if (rx_valid === 1'b1) break;
        end
        if (t == 3000) begin
            n_fail++;
            $display("unexpected at %0t: no received byte", $time);
        end
    endtask

    task automatic push(input logic [7:0] b);
        tx_data <= b;
        tx_valid <= 1'b1;
        @(negedge clk);
        while (tx_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask

    // ------
    // Scenarios
    // ------
    task automatic t_reset();
        chk1(line_o, 1'b0);
        chk1(line_oe, 1'b0);
        chk1(far_level, 1'b1);
        chk1(rx_valid, 1'b0);
        chk1(rx_frame_err, 1'b0);
        chk8(rx_data, 8'h00);
        $display("test reset done");
    endtask

    // Fill past the buffer, then check every byte on the wire
    task automatic t_fill();
        int n;
        n = 0;
        far_lo = 0;
        while (n < 20) begin
            tx_data <= 8'(n * 17);
            tx_valid <= 1'b1;
            @(negedge clk);
            if (tx_ready !== 1'b1) break;
            @(posedge clk);
            n++;
        end
        chk1(tx_ready, 1'b0);
        repeat (3) @(posedge clk);
        tx_valid <= 1'b0;
        // Buffer full plus the holding word and the word on the wire
        chk1(n == int'(TX_FIFO_DEPTH) + 2, 1'b1);
        for (int i = 0; i < n; i++) begin
            wait_kbd(i + 1);
            chk8(KBD.got_data, 8'(i * 17));
            chk1(KBD.got_err, 1'b0);
        end
        chk1(far_lo == 0, 1'b1);
        $display("test fill done");
    endtask

    // Both ends send at once
    task automatic t_duplex();
        int g;
        g = KBD.got_cnt;
        push(8'h00);
        fork
            KBD.send_byte(8'h3c, 1'b1);
            wait_rx();
        join
        chk8(rx_data, 8'h3c);
        chk1(rx_frame_err, 1'b0);
        wait_kbd(g + 1);
        chk8(KBD.got_data, 8'h00);
        $display("test duplex done");
    endtask

    // Bad stop bit, then a clean byte
    task automatic t_ferr();
        fork
            KBD.send_byte(8'ha5, 1'b0);
            wait_rx();
        join
        chk8(rx_data, 8'ha5);
        chk1(rx_frame_err, 1'b1);
        repeat (32) @(KBD.tick);
        fork
            KBD.send_byte(8'h5a, 1'b1);
            wait_rx();
        join
        chk8(rx_data, 8'h5a);
        chk1(rx_frame_err, 1'b0);
        $display("test frame error done");
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        #1;
        t_reset();
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_fill();
        t_duplex();
        t_ferr();
        conclude();
    end
endmodule
